// ### iowdt_defs.vh
// Constants for the I/O port watchdog timer.
`ifndef IOWDT_DEFS_VH
`define IOWDT_DEFS_VH

`define IOWDT_ADDR_W 16
`define IOWDT_PERIOD_PORT 16'h0443
`define IOWDT_DISABLE_PORT 16'h0843
`define IOWDT_DISABLE_ALIAS 16'h0043
`define IOWDT_PERIOD_RESET 8'h01
`define IOWDT_CLK_HZ 100000000
`define IOWDT_SECOND_S 1
`define IOWDT_TICKS_PER_SEC (`IOWDT_CLK_HZ * `IOWDT_SECOND_S)
`define IOWDT_RST_PULSE_NS 1000
`define IOWDT_CLK_NS 10
`define IOWDT_RST_PULSE_CYC (`IOWDT_RST_PULSE_NS / `IOWDT_CLK_NS)
`define IOWDT_IDLE_DATA 8'hFF

`endif

// ### iowdt_tick.v
// Seconds timebase that restarts on every load of the countdown.
`timescale 1ns/1ps
`default_nettype none
`include "iowdt_defs.vh"

module iowdt_tick #(
    parameter [31:0] TICKS = `IOWDT_TICKS_PER_SEC
) (
    input wire clk,
    input wire nrst,
    input wire restart,
    output reg tick
);

    reg [31:0] cnt_reg;

    // Restarting the prescaler keeps a refresh worth one full period, not a fraction less.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 32'h00000000;
            tick <= 1'b0;
        end else if (restart) begin
            cnt_reg <= 32'h00000000;
            tick <= 1'b0;
        end else if (cnt_reg == TICKS - 32'h00000001) begin
            cnt_reg <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
            tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### iowdt_core.v
// Watchdog timer reached by host I/O port reads and writes.
// Behaviour
// RULE1: A write to the period port loads the written byte as the period.
// RULE2: A read of the period port starts an idle watchdog or refreshes a running one.
// RULE3: A read of the disable port at either alias stops the watchdog.
// RULE4: The period byte counts whole seconds, 1 to 255.
// RULE5: Enabling starts a countdown of the programmed period.
// RULE6: When the countdown expires a cold reset of the CPU is asserted.
// RULE7: Software writes the period before the enabling read.
// RULE8: Software refreshes the running watchdog within the period.
// RULE9: Software keeps a margin of at least five percent before timeout.
// RULE10: Each refresh reloads the full programmed period.
`timescale 1ns/1ps
`default_nettype none
`include "iowdt_defs.vh"

module iowdt_core #(
    parameter [31:0] TICKS_PER_SEC = `IOWDT_TICKS_PER_SEC
) (
    input wire clk,
    input wire nrst,
    input wire [15:0] io_addr,
    input wire io_rd_n,
    input wire io_wr_n,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    output wire io_sel,
    output reg cpu_reset,
    output wire running
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg [2:0] rd_sync_reg;
    reg [2:0] wr_sync_reg;
    reg [15:0] addr_s1_reg;
    reg [15:0] addr_reg;
    reg [7:0] data_s1_reg;
    reg [7:0] data_reg;
    reg [7:0] period_reg;
    reg [7:0] count_reg;
    reg state_reg;
    reg [7:0] pulse_reg;
    wire rd_pulse;
    wire wr_pulse;
    wire hit_period;
    wire hit_disable;
    wire kick;
    wire stop;
    wire sec_tick;
    wire tick_restart;
    wire expire;
    reg [7:0] period_next;
    reg [7:0] count_next;
    reg state_next;
    reg [7:0] pulse_next;
    reg cpu_reset_next;
    reg [7:0] rdata_next;
    // The reset pulse length is cut to the counter width on purpose.
    localparam [31:0] PULSE_CYC_W = `IOWDT_RST_PULSE_CYC;
    localparam [7:0] PULSE_CYC = PULSE_CYC_W[7:0];

    function is_disable;
        input [15:0] a;
        begin
            is_disable = (a == `IOWDT_DISABLE_PORT) || (a == `IOWDT_DISABLE_ALIAS);
        end
    endfunction

    // Strobes are async pins; only the second stage and later are looked at.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_sync_reg <= 3'h7;
            wr_sync_reg <= 3'h7;
            addr_s1_reg <= 16'h0000;
            addr_reg <= 16'h0000;
            data_s1_reg <= 8'h00;
            data_reg <= 8'h00;
        end else begin
            rd_sync_reg <= {rd_sync_reg[1:0], io_rd_n};
            wr_sync_reg <= {wr_sync_reg[1:0], io_wr_n};
            addr_s1_reg <= io_addr;
            addr_reg <= addr_s1_reg;
            data_s1_reg <= io_wdata;
            data_reg <= data_s1_reg;
        end
    end

    assign rd_pulse = rd_sync_reg[2] & ~rd_sync_reg[1];
    assign wr_pulse = wr_sync_reg[2] & ~wr_sync_reg[1];
    assign hit_period = (addr_reg == `IOWDT_PERIOD_PORT);
    assign hit_disable = is_disable(addr_reg);
    assign kick = rd_pulse & hit_period;
    assign stop = rd_pulse & hit_disable;
    assign io_sel = hit_period | hit_disable;
    assign running = (state_reg == ST_RUN);
    assign tick_restart = kick | stop;

    iowdt_tick #(
        .TICKS(TICKS_PER_SEC)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .restart(tick_restart),
        .tick(sec_tick)
    );

    // A zero period would wrap the count to 255 and run 256 seconds, so it is treated as one second.
    function [7:0] reload_val;
        input [7:0] per;
        begin
            if (per == 8'h00) begin
                reload_val = 8'h01;
            end else begin
                reload_val = per;
            end
        end
    endfunction

    // The timebase assumes the default clock; another board clock needs TICKS_PER_SEC changed.
    // The last tick of a running count ends the run; the reset pulse follows a cycle later.
    assign expire = sec_tick && (count_reg == 8'h01);

    // Writes to the disable port are dropped; only the period port holds data.
    always @* begin
        period_next = period_reg;
        if (wr_pulse && hit_period) begin
            period_next = data_reg; // see RULE1
        end
    end

    // Stop outranks a refresh in the same cycle, so a disable is never undone by a late read.
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (kick) begin
                    state_next = ST_RUN; // see RULE2
                    count_next = reload_val(period_reg); // see RULE5
                end
            end
            ST_RUN: begin
                if (stop) begin
                    state_next = ST_IDLE; // see RULE3
                end else if (kick) begin
                    count_next = reload_val(period_reg); // see RULE10
                end else if (sec_tick) begin
                    if (expire) begin
                        state_next = ST_IDLE; // see RULE6
                    end
                    count_next = count_reg - 8'h01; // see RULE4
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // The pulse counter runs on its own so a new start during the pulse cannot cut it short.
    always @* begin
        pulse_next = pulse_reg;
        if (state_reg == ST_RUN && !stop && !kick && expire) begin
            pulse_next = PULSE_CYC; // see RULE6
        end else if (pulse_reg != 8'h00) begin
            pulse_next = pulse_reg - 8'h01;
        end
        cpu_reset_next = (pulse_reg != 8'h00);
    end

    // Reads of the period port return the seconds left, other addresses the bus idle level.
    always @* begin
        if (hit_period) begin
            rdata_next = count_reg;
        end else begin
            rdata_next = `IOWDT_IDLE_DATA;
        end
    end

    // The period survives a disable or an expiry, so a restart needs no new write.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            period_reg <= `IOWDT_PERIOD_RESET;
        end else begin
            period_reg <= period_next;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // The pulse output is registered so the CPU reset line never glitches.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_reg <= 8'h00;
            cpu_reset <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
            cpu_reset <= cpu_reset_next;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= `IOWDT_IDLE_DATA;
        end else begin
            io_rdata <= rdata_next;
        end
    end

endmodule
`default_nettype wire

// ### iowdt_props.sv
// Checker of the port watchdog timing seen at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module iowdt_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] io_addr,
    input wire logic io_rd_n,
    input wire logic [7:0] io_rdata,
    input wire logic io_sel,
    input wire logic cpu_reset,
    input wire logic running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    pulse_len_a: assert property ($rose(cpu_reset) |-> ##99 cpu_reset ##1 !cpu_reset)
        else $error("reset pulse length wrong");
    pulse_hold_a: assert property ($rose(cpu_reset) |-> cpu_reset[*8])
        else $error("reset pulse broken");
    pulse_cause_a: assert property ($rose(cpu_reset) |-> !running && $past(running, 2))
        else $error("reset without expiry");
    pulse_gap_a: assert property ($fell(cpu_reset) |-> !cpu_reset[*8])
        else $error("reset pulse repeated");
    // With ten ticks a second even one second outlasts eight cycles.
    run_hold_a: assert property ($rose(running) |-> running[*8])
        else $error("countdown too short");
    start_src_a: assert property ($rose(running) |->
        !$past(io_rd_n, 2) && $past(io_addr, 2) == 16'h0443)
        else $error("start without period read");
    stop_src_a: assert property ($fell(running) |-> ##1 (cpu_reset || !$past(io_rd_n, 3)))
        else $error("stop without cause");
    sel_dec_a: assert property (io_sel |->
        $past(io_addr, 2) inside {16'h0443, 16'h0843, 16'h0043})
        else $error("select on foreign address");
    rdata_idle_a: assert property (!$past(io_sel) |-> io_rdata == 8'hFF)
        else $error("read data not idle");
    cover property ($rose(running));
    cover property ($rose(cpu_reset));
    cover property ($fell(running) ##1 !cpu_reset);
endmodule
`default_nettype wire

// ### iowdt_core_tb.sv
// Self-checking bench for the port watchdog.
`timescale 1ns/1ps
`default_nettype none
module iowdt_core_tb;
    logic clk = 0, nrst = 0, io_rd_n = 1, io_wr_n = 1;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00, p;
    wire [7:0] io_rdata;
    wire io_sel, cpu_reset, running;
    int errors = 0, tests_run = 0, n;
    integer seed = 54;
    always #5 clk = ~clk;
    iowdt_core #(.TICKS_PER_SEC(10)) iowdt_core_i (.clk(clk), .nrst(nrst), .io_addr(io_addr),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_sel(io_sel), .cpu_reset(cpu_reset), .running(running));
    function int due(input logic [7:0] q);
        return q * 10;
    endfunction
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task results;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Address and data settle four cycles ahead because the block synchronises them.
    task io(input logic [15:0] a, input logic wr, input logic [7:0] d);
        @(posedge clk) #1 io_addr = a;
        io_wdata = d;
        repeat (4) @(posedge clk);
        #1 io_wr_n = ~wr;
        io_rd_n = wr;
        repeat (4) @(posedge clk);
        #1 io_wr_n = 1;
        io_rd_n = 1;
        repeat (3) @(posedge clk);
    endtask
    task expire(input logic [7:0] q);
        n = 0;
        while (cpu_reset !== 1'b1 && n < 3000) begin
            @(posedge clk) #1 n++;
        end
        chk("expiry", 1, n >= due(q) - 6 && n <= due(q) + 2);
        if (n >= 3000)
            results;
        repeat (110) @(posedge clk);
        chk("pulse", 0, {cpu_reset, running});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 nrst = 1;
        chk("idle", 16'h00FF, {cpu_reset, running, io_rdata});
        for (int i = 0; i < 4; i++) begin
            p = i == 0 ? 8'h01 : i == 1 ? 8'hFF : 8'h02 + ($random(seed) & 8'h07);
            io(16'h0443, 1, p);
            io(16'h0443, 0, 8'h00);
            chk("start", 1, running);
            chk("count", {8'h00, p}, io_rdata);
            chk("select", 1, io_sel);
            if (i > 1) begin
                repeat (due(p) - 20) @(posedge clk);
                io(16'h0443, 0, 8'h00);
            end
            expire(p);
        end
        for (int i = 0; i < 2; i++) begin
            io(16'h0443, 0, 8'h00);
            io(i ? 16'h0043 : 16'h0843, 0, 8'h00);
            chk("stop", 0, running);
            chk("select", 1, io_sel);
            chk("idle data", 16'h00FF, io_rdata);
            repeat (due(p) + 20) @(posedge clk);
            chk("no reset", 0, cpu_reset);
        end
        results;
    end
endmodule
bind iowdt_core iowdt_props iowdt_props_i (.clk(clk), .nrst(nrst), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_rdata(io_rdata), .io_sel(io_sel), .cpu_reset(cpu_reset),
    .running(running));
`default_nettype wire
